/* File: hdl/ssm_pkg.sv */
`default_nettype none
package ssm_pkg;
  // Register offsets (printed addresses, 16-bit words)
  localparam logic [7:0] SSM_ADDR_AEC_GAIN = 8'hbc;
  localparam logic [7:0] SSM_ADDR_MON_CFG = 8'hc0;
  localparam logic [7:0] SSM_ADDR_STEP_MULT = 8'hd0;
  localparam logic [7:0] SSM_ADDR_RESET_TIME = 8'hd1;
  localparam logic [7:0] SSM_ADDR_INT_TIME = 8'hd2;
  localparam logic [7:0] SSM_ADDR_KNEE2 = 8'hd3;
  localparam logic [7:0] SSM_ADDR_KNEE3 = 8'hd4;
  localparam logic [7:0] SSM_ADDR_ANA_GAIN = 8'hd5;
  localparam logic [7:0] SSM_ADDR_FINE_GAIN = 8'hd6;
  localparam logic [7:0] SSM_ADDR_TEMP = 8'hd7;
  localparam logic [7:0] SSM_ADDR_TEMP_EN = 8'hd8;
  // Field positions
  localparam int SSM_AEC_DGAIN_LSB = 4;
  localparam int SSM_MON_SEL_LSB = 11;
  localparam int SSM_GAIN1_LSB = 0;
  localparam int SSM_GAIN2_LSB = 5;
  // Values after reset
  localparam logic [15:0] SSM_RST_WORD = 16'h0000;
  localparam logic [15:0] SSM_RST_MON_CFG = 16'h0000;
  localparam logic SSM_RST_TEMP_EN = 1'b0;

  typedef struct packed {
    logic [15:0] step_mult;
    logic [15:0] reset_time;
    logic [15:0] int_time;
    logic [15:0] knee2;
    logic [15:0] knee3;
    logic [4:0] gain1;
    logic [7:0] gain2;
    logic [11:0] fine_gain;
  } ssm_settings_t;

  // Sequencer indications, levels and start-of events
  typedef struct packed {
    logic integrating;
    logic row_overhead;
    logic multi_slope_fot;
    logic black_line;
    logic first_line;
    logic frame_start;
    logic row_overhead_start;
    logic readout_start;
    logic readout_start_black;
    logic readout_start_image;
  } ssm_seq_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } ssm_reg_req_t;
endpackage : ssm_pkg
`default_nettype wire

/* File: hdl/ssm_monitor.sv */
`default_nettype none
// How it works
// - Auto-exposure digital gain copy (5.7 format) refreshes only at frame end.
// - Sequencer status fields update only when setting takes effect on image.
// - Report applied step multiplier and array reset time, global shutter only.
// - Report main, second and third knee times; knees never from exposure loop.
// - Analog gains in bits 4:0 and 12:5; fine gain 5.7 in 11:0.
// - Junction temperature is unsigned 8-bit count, 0 to 255.
// - Temperature count readable over serial register interface by host.
// - Thermometer runs only when enable high; held reset when low.
// - Monitor select is bits 13:11 of configuration register 192.
// - Selects 0 to 2 drive low, integration, overhead, multi-slope indications.
// - Selects 3 and 4 show readout start, black line, frame and overhead start.
// - Selects 5 to 7 show first line, overhead, readout start variants.
// - Exposure-loop status updates at frame end after a request, leading sequencer-side status.
module ssm_monitor (
  input wire logic clk,
  input wire logic nrst,
  // Register port from the serial interface
  input wire ssm_pkg::ssm_reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  output logic reg_hit,
  // Auto exposure loop request and frame end
  input wire logic aec_request,
  input wire logic [11:0] aec_dgain,
  input wire logic frame_end,
  // Sequencer: settings and the moment they take effect
  input wire ssm_pkg::ssm_settings_t seq_settings,
  input wire logic seq_apply,
  input wire logic global_shutter,
  input wire ssm_pkg::ssm_seq_t seq_ind,
  // Thermometer
  input wire logic [7:0] thermo_count,
  input wire logic thermo_valid,
  output logic thermo_run_n,
  // Monitor pins
  output logic observe_pin_zero,
  output logic observe_pin_one
);
  import ssm_pkg::*;

  // One-hot register decode; shared by the write path and the read hit flag
  function automatic logic [10:0] reg_decode(input logic [7:0] addr);
    logic [10:0] sel;
    sel = 11'h000;
    case (addr)
      SSM_ADDR_AEC_GAIN: sel[0] = 1'b1;
      SSM_ADDR_MON_CFG: sel[1] = 1'b1;
      SSM_ADDR_STEP_MULT: sel[2] = 1'b1;
      SSM_ADDR_RESET_TIME: sel[3] = 1'b1;
      SSM_ADDR_INT_TIME: sel[4] = 1'b1;
      SSM_ADDR_KNEE2: sel[5] = 1'b1;
      SSM_ADDR_KNEE3: sel[6] = 1'b1;
      SSM_ADDR_ANA_GAIN: sel[7] = 1'b1;
      SSM_ADDR_FINE_GAIN: sel[8] = 1'b1;
      SSM_ADDR_TEMP: sel[9] = 1'b1;
      SSM_ADDR_TEMP_EN: sel[10] = 1'b1;
      default: sel = 11'h000;
    endcase
    return sel;
  endfunction : reg_decode

  // Rising edge of a level against its copy one cycle old
  function automatic logic rise(input logic now_lvl, input logic old_lvl);
    return now_lvl && !old_lvl;
  endfunction : rise

  // Register state
  logic [15:0] aec_gain_status;
  logic [15:0] monitor_config;
  ssm_settings_t applied;
  logic [7:0] junction_temp_count;
  logic thermometer_enable;
  logic aec_pending;
  logic [11:0] aec_hold;
  logic [2:0] mon_sel;
  logic p_rot_start;
  logic p_ro;
  logic p_rob;
  logic p_roi;
  logic p_fs;
  logic next_pin0;
  logic next_pin1;
  logic [15:0] next_rdata;
  logic next_hit;

  // Decode and commit nets
  logic [10:0] reg_sel;
  logic sel_mon_cfg;
  logic sel_temp_en;
  logic wr_mon_cfg;
  logic wr_temp_en;
  logic aec_commit;
  logic [11:0] aec_next_gain;

  // Bus views of the narrow status fields
  logic [15:0] word_ana_gain;
  logic [15:0] word_fine_gain;
  logic [15:0] word_temp;
  logic [15:0] word_temp_en;

  // Start-of levels and their one-cycle pulses
  logic [4:0] start_lvl;
  wire logic [4:0] start_pulse;

  // Frame end commits the newest request; a request in that same cycle wins over the held one
  assign aec_commit = frame_end && (aec_pending || aec_request);
  assign aec_next_gain = aec_request ? aec_dgain : aec_hold;

  // Request latched from the loop; copied out at frame end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      aec_pending <= 1'b0;
      aec_hold <= 12'h000;
      aec_gain_status <= SSM_RST_WORD;
    end else begin
      if (aec_request) begin
        aec_pending <= 1'b1;
        aec_hold <= aec_dgain;
      end
      if (aec_commit) begin
        aec_gain_status <= {aec_next_gain, 4'h0};
        aec_pending <= 1'b0;
      end
    end
  end

  // Sequencer copy lags: only taken when the frame actually uses it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      applied <= '0;
    end else if (seq_apply) begin
      applied.int_time <= seq_settings.int_time;
      applied.knee2 <= seq_settings.knee2;
      applied.knee3 <= seq_settings.knee3;
      applied.gain1 <= seq_settings.gain1;
      applied.gain2 <= seq_settings.gain2;
      applied.fine_gain <= seq_settings.fine_gain;
      // Rolling shutter keeps the last global values; they have no meaning there
      if (global_shutter) begin
        applied.step_mult <= seq_settings.step_mult;
        applied.reset_time <= seq_settings.reset_time;
      end
    end
  end

  // Address decode as named wires; writes aimed at read-only words match nothing writable
  assign reg_sel = reg_decode(reg_req.addr);
  assign sel_mon_cfg = reg_sel[1];
  assign sel_temp_en = reg_sel[10];
  assign wr_mon_cfg = reg_req.wr && sel_mon_cfg;
  assign wr_temp_en = reg_req.wr && sel_temp_en;
  assign next_hit = |reg_sel;

  // Writable config; the whole monitor word is kept for read-back, the enable keeps only bit 0
  always_ff @(posedge clk) begin
    if (!nrst) begin
      monitor_config <= SSM_RST_MON_CFG;
      thermometer_enable <= SSM_RST_TEMP_EN;
    end else begin
      if (wr_mon_cfg) begin
        monitor_config <= reg_req.wdata;
      end
      if (wr_temp_en) begin
        thermometer_enable <= reg_req.wdata[0];
      end
    end
  end

  // Sensor held in reset whenever the enable bit is low
  assign thermo_run_n = !thermometer_enable;

  // Temperature count; cleared one cycle after the sensor goes off, so a stale reading shows in that one cycle only
  always_ff @(posedge clk) begin
    if (!nrst || !thermometer_enable) begin
      junction_temp_count <= 8'h00;
    end else if (thermo_valid) begin
      junction_temp_count <= thermo_count;
    end
  end

  // Narrow fields zero-filled to the bus width
  assign word_ana_gain = {3'h0, applied.gain2, applied.gain1};
  assign word_fine_gain = {4'h0, applied.fine_gain};
  assign word_temp = {8'h00, junction_temp_count};
  assign word_temp_en = {15'h0000, thermometer_enable};

  // Read data select; unmapped offsets read as zero
  always_comb begin
    next_rdata = 16'h0000;
    case (reg_req.addr)
      SSM_ADDR_AEC_GAIN: next_rdata = aec_gain_status;
      SSM_ADDR_MON_CFG: next_rdata = monitor_config;
      SSM_ADDR_STEP_MULT: next_rdata = applied.step_mult;
      SSM_ADDR_RESET_TIME: next_rdata = applied.reset_time;
      SSM_ADDR_INT_TIME: next_rdata = applied.int_time;
      SSM_ADDR_KNEE2: next_rdata = applied.knee2;
      SSM_ADDR_KNEE3: next_rdata = applied.knee3;
      SSM_ADDR_ANA_GAIN: next_rdata = word_ana_gain;
      SSM_ADDR_FINE_GAIN: next_rdata = word_fine_gain;
      SSM_ADDR_TEMP: next_rdata = word_temp;
      SSM_ADDR_TEMP_EN: next_rdata = word_temp_en;
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // Read data registered one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
      reg_hit <= 1'b0;
    end else if (reg_req.rd) begin
      reg_rdata <= next_rdata;
      reg_hit <= next_hit;
    end
  end

  // Start-of fields gathered so one detector shape serves all five
  assign start_lvl = {seq_ind.row_overhead_start,
    seq_ind.readout_start, seq_ind.readout_start_black,
    seq_ind.readout_start_image, seq_ind.frame_start};

  // One detector each; a long start level still yields one pulse, reset low so a level already high at reset exit gives one
  for (genvar i = 0; i < 5; i++) begin : g_edge
    logic prev_q;
    always_ff @(posedge clk) begin
      if (!nrst) begin
        prev_q <= 1'b0;
      end else begin
        prev_q <= start_lvl[i];
      end
    end
    assign start_pulse[i] = rise(start_lvl[i], prev_q);
  end

  // Named pulses for the selection table
  assign p_rot_start = start_pulse[4];
  assign p_ro = start_pulse[3];
  assign p_rob = start_pulse[2];
  assign p_roi = start_pulse[1];
  assign p_fs = start_pulse[0];

  // Select sits in the upper bits; the rest of the word is only stored
  assign mon_sel = monitor_config[SSM_MON_SEL_LSB +: 3];

  // Pin selection table
  always_comb begin
    case (mon_sel)
      3'h0: begin
        next_pin0 = 1'b0;
        next_pin1 = 1'b0;
      end
      3'h1: begin
        next_pin0 = seq_ind.integrating;
        next_pin1 = seq_ind.row_overhead;
      end
      3'h2: begin
        next_pin0 = seq_ind.integrating;
        next_pin1 = seq_ind.multi_slope_fot;
      end
      3'h3: begin
        next_pin0 = p_ro;
        next_pin1 = seq_ind.black_line;
      end
      3'h4: begin
        next_pin0 = p_fs;
        next_pin1 = p_rot_start;
      end
      3'h5: begin
        next_pin0 = seq_ind.first_line;
        next_pin1 = p_rot_start;
      end
      3'h6: begin
        next_pin0 = seq_ind.row_overhead;
        next_pin1 = p_ro;
      end
      3'h7: begin
        next_pin0 = p_rob;
        next_pin1 = p_roi;
      end
      default: begin
        next_pin0 = 1'b0;
        next_pin1 = 1'b0;
      end
    endcase
  end

  // Pins registered to keep them glitch-free off chip
  always_ff @(posedge clk) begin
    if (!nrst) begin
      observe_pin_zero <= 1'b0;
      observe_pin_one <= 1'b0;
    end else begin
      observe_pin_zero <= next_pin0;
      observe_pin_one <= next_pin1;
    end
  end
endmodule : ssm_monitor
`default_nettype wire

/* File: test/ssm_asserts.sv */
`default_nettype none
module ssm_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire ssm_pkg::ssm_reg_req_t reg_req,
  input wire logic [15:0] reg_rdata,
  input wire ssm_pkg::ssm_settings_t seq_settings,
  input wire logic seq_apply,
  input wire ssm_pkg::ssm_seq_t seq_ind,
  input wire logic [7:0] thermo_count,
  input wire logic thermo_valid,
  input wire logic thermo_run_n,
  input wire logic observe_pin_zero,
  input wire logic observe_pin_one
);
  import ssm_pkg::*;
  logic [2:0] sel_q;
  logic en_q;
  // Shadow of select and enable, so pin checks know the mode
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sel_q <= 3'h0;
      en_q <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == SSM_ADDR_MON_CFG) begin
      sel_q <= reg_req.wdata[13:11];
    end else if (reg_req.wr && reg_req.addr == SSM_ADDR_TEMP_EN) begin
      en_q <= reg_req.wdata[0];
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Conversion captured, then read straight after
  sequence s_temp;
    thermo_valid && en_q ##1 reg_req.rd && reg_req.addr == SSM_ADDR_TEMP && !thermo_valid;
  endsequence
  sequence s_apply;
    seq_apply ##1 reg_req.rd && reg_req.addr == SSM_ADDR_INT_TIME && !seq_apply;
  endsequence
  AST_SEL0: assert property (sel_q == 3'h0 |=> !observe_pin_zero && !observe_pin_one)
    else $error("select 0 pins not low");
  AST_SEL1: assert property (sel_q == 3'h1 |=> observe_pin_zero == $past(seq_ind.integrating)
    && observe_pin_one == $past(seq_ind.row_overhead)) else $error("select 1 pins wrong");
  AST_SEL3: assert property (sel_q == 3'h3 |=> observe_pin_one == $past(seq_ind.black_line)
    && observe_pin_zero == ($past(seq_ind.readout_start) && !$past(seq_ind.readout_start, 2)))
    else $error("select 3 pins wrong");
  AST_SEL7: assert property (sel_q == 3'h7 |=>
    observe_pin_zero == ($past(seq_ind.readout_start_black) && !$past(seq_ind.readout_start_black, 2))
    && observe_pin_one == ($past(seq_ind.readout_start_image) && !$past(seq_ind.readout_start_image, 2)))
    else $error("select 7 pins wrong");
  AST_PULSE: assert property ($stable(sel_q) && sel_q == 3'h4 && observe_pin_one |=> !observe_pin_one)
    else $error("start pulse longer than one cycle");
  AST_TEMP: assert property (s_temp |=> reg_rdata[7:0] == $past(thermo_count, 2))
    else $error("temperature count not read back");
  AST_RUN: assert property (reg_req.wr && reg_req.addr == SSM_ADDR_TEMP_EN |=>
    thermo_run_n == !$past(reg_req.wdata[0])) else $error("sensor hold wrong");
  AST_APPLY: assert property (s_apply |=> reg_rdata == $past(seq_settings.int_time, 2))
    else $error("applied time not captured");
endmodule : ssm_asserts
`default_nettype wire

/* File: test/ssm_pin_watch.sv */
`default_nettype none
module ssm_pin_watch (
  input wire logic clk,
  input wire logic pin_zero,
  input wire logic pin_one,
  output int rises
);
  logic p0_q = 1'b0;
  logic p1_q = 1'b0;
  initial rises = 0;
  // Edge counter; a stuck or doubled pulse shows in the total
  always @(posedge clk) begin
    rises <= rises + int'(pin_zero && !p0_q) + int'(pin_one && !p1_q);
    p0_q <= pin_zero;
    p1_q <= pin_one;
  end
endmodule : ssm_pin_watch
`default_nettype wire

/* File: test/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ssm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  ssm_reg_req_t reg_req = '0;
  logic [15:0] reg_rdata;
  logic reg_hit;
  logic aec_request = 1'b0;
  logic [11:0] aec_dgain = 12'h0;
  logic frame_end = 1'b0;
  ssm_settings_t seq_settings = '0;
  logic seq_apply = 1'b0;
  logic global_shutter = 1'b1;
  ssm_seq_t seq_ind = '0;
  logic [7:0] thermo_count = 8'h0;
  logic thermo_valid = 1'b0;
  logic thermo_run_n;
  logic observe_pin_zero;
  logic observe_pin_one;
  int rises;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [15:0] exp_q [0:6];
  logic [1:0] mid [0:8] = '{2'h0, 2'h3, 2'h3, 2'h1, 2'h0, 2'h2, 2'h2, 2'h0, 2'h0};
  always #5 clk = ~clk;
  ssm_monitor dut_u (.clk, .nrst, .reg_req, .reg_rdata, .reg_hit, .aec_request, .aec_dgain, .frame_end,
    .seq_settings, .seq_apply, .global_shutter, .seq_ind, .thermo_count, .thermo_valid, .thermo_run_n,
    .observe_pin_zero, .observe_pin_one);
  ssm_pin_watch watch_u (.clk, .pin_zero(observe_pin_zero), .pin_one(observe_pin_one), .rises);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bus tasks start and end on a falling edge; strobes last one cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    reg_req = '0;
    @(negedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic hit);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0};
    @(negedge clk);
    reg_req = '0;
    @(negedge clk);
    chk(reg_rdata, exp);
    chk({15'h0, reg_hit}, {15'h0, hit});
  endtask : rd
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  // Watchdog: the sequence needs under a hundred cycles
  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    thermo_count = 8'hff;
    pulse(thermo_valid);
    rd(SSM_ADDR_TEMP, 16'h0, 1'b1);
    chk({15'h0, thermo_run_n}, 16'h1);
    wr(SSM_ADDR_TEMP_EN, 16'h1);
    pulse(thermo_valid);
    rd(SSM_ADDR_TEMP, 16'h00ff, 1'b1);
    chk({15'h0, thermo_run_n}, 16'h0);
    $display("thermometer test done");
    aec_dgain = 12'habc;
    pulse(aec_request);
    rd(SSM_ADDR_AEC_GAIN, 16'h0, 1'b1);
    pulse(frame_end);
    rd(SSM_ADDR_AEC_GAIN, 16'habc0, 1'b1);
    aec_dgain = 12'h123;
    pulse(frame_end);
    rd(SSM_ADDR_AEC_GAIN, 16'habc0, 1'b1);
    $display("exposure loop test done");
    seq_settings = {16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555, 5'h15, 8'ha6, 12'h9c7};
    exp_q = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h14d5, 16'h09c7};
    rd(SSM_ADDR_INT_TIME, 16'h0, 1'b1);
    pulse(seq_apply);
    for (int i = 0; i < 7; i++) begin
      rd(SSM_ADDR_STEP_MULT + 8'(i), exp_q[i], 1'b1);
    end
    global_shutter = 1'b0;
    seq_settings = ~seq_settings;
    pulse(seq_apply);
    rd(SSM_ADDR_INT_TIME, 16'hcccc, 1'b1);
    rd(SSM_ADDR_STEP_MULT, 16'h1111, 1'b1);
    rd(8'hc1, 16'h0, 1'b0);
    $display("sequencer status test done");
    // Every field rises at once, then holds: level modes stay, starts drop
    for (int s = 0; s < 8; s++) begin
      wr(SSM_ADDR_MON_CFG, 16'(s) << 11);
      seq_ind = '1;
      @(negedge clk);
      chk({14'h0, observe_pin_zero, observe_pin_one}, (s == 0) ? 16'h0 : 16'h3);
      @(negedge clk);
      chk({14'h0, observe_pin_zero, observe_pin_one}, 16'(mid[s]));
      seq_ind = '0;
    end
    rd(SSM_ADDR_MON_CFG, 16'h3800, 1'b1);
    chk(16'(rises), 16'd14);
    $display("monitor pin test done");
    report_and_stop();
  end
endmodule : tb
bind ssm_monitor ssm_asserts chk_u (.clk, .nrst, .reg_req, .reg_rdata, .seq_settings, .seq_apply, .seq_ind,
  .thermo_count, .thermo_valid, .thermo_run_n, .observe_pin_zero, .observe_pin_one);
`default_nettype wire
